// [src/ppc_ctrl.sv]
// Port power controller: supervision, pin decode, indicators and switches.
module ppc_ctrl #(
    parameter int unsigned MASK_CYC = ppc_pkg::MASK_CYC,
    parameter int unsigned BLANK_CYC = ppc_pkg::BLANK_CYC,
    parameter int unsigned CYCLE_CYC = ppc_pkg::CYCLE_CYC,
    parameter bit CHARGE_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Host control pins and analog sense inputs
    input wire ppc_pkg::ppc_ctl_t ctl,
    input wire ppc_pkg::ppc_sense_t sense,
    // Switch drives and status
    output ppc_pkg::ppc_sw_t sw,
    output ppc_pkg::ppc_state_t power_state,
    output logic back_voltage_flag,
    output logic [2:0] limit_step,
    // Open-drain indicators, low when enabled
    output logic alert_n_o,
    output logic alert_n_oe,
    output logic charging_active_n_o,
    output logic charging_active_n_oe,
    output logic attach_indicator_n_o,
    output logic attach_indicator_n_oe
);

    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    ppc_pkg::ppc_ctl_t c_s;
    ppc_pkg::ppc_sense_t s_s;

    ppc_sync #(.W($bits(ppc_pkg::ppc_ctl_t))) u_sync_ctl (
        .mclk(mclk),
        .reset_n(reset_n),
        .d(ctl),
        .q(c_s)
    );

    ppc_sync #(.W($bits(ppc_pkg::ppc_sense_t))) u_sync_sense (
        .mclk(mclk),
        .reset_n(reset_n),
        .d(sense),
        .q(s_s)
    );

    // ----------------------------------------------------------------
    // Power-up capture and blanking
    // ----------------------------------------------------------------
    logic [ppc_pkg::CNT_W-1:0] blank_cnt_r;
    logic blank_done_r;
    logic cap_done_r;
    logic pol_r;
    logic [2:0] limit_step_r;
    wire capture_now = !cap_done_r && (blank_cnt_r == ppc_pkg::CAPTURE_AT);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            blank_cnt_r <= '0;
            blank_done_r <= 1'b0;
            cap_done_r <= 1'b0;
            pol_r <= ppc_pkg::POL_RST;
            limit_step_r <= ppc_pkg::LIMIT_STEP_RST;
        end else begin
            if (!blank_done_r) begin
                blank_cnt_r <= blank_cnt_r + 1'b1;
            end
            blank_done_r <= blank_done_r || (blank_cnt_r >= ppc_pkg::CNT_W'(BLANK_CYC));
            if (capture_now) begin
                cap_done_r <= 1'b1;
                pol_r <= c_s.polarity_select;
                limit_step_r <= c_s.current_limit_strap;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin decode
    // ----------------------------------------------------------------
    ppc_pkg::ppc_state_t state_r;
    ppc_pkg::ppc_state_t state_nxt;
    ppc_pkg::ppc_state_t want;
    ppc_pkg::ppc_sw_t sw_nxt;

    wire en_on = !(c_s.power_enable ^ pol_r);
    wire det_en = c_s.detect_enable;
    wire modes_zero = !(c_s.mode_select_a | c_s.mode_select_b | c_s.emulation_enable);
    wire src_ok = s_s.source_above_uvlo;
    wire core_ok = s_s.core_supply_ok;
    // Detection runs only with detect-enable set, and not with all modes zero while power enable is on.
    wire detect_on = det_en && !(modes_zero && en_on);

    logic attach_prev_r;
    logic removal_prev_r;
    logic attached_r;
    wire attach_pulse = s_s.attach_seen && !attach_prev_r;
    wire removal_pulse = s_s.removal_seen && !removal_prev_r && detect_on;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            attach_prev_r <= 1'b0;
            removal_prev_r <= 1'b0;
            attached_r <= 1'b0;
        end else begin
            attach_prev_r <= s_s.attach_seen;
            removal_prev_r <= s_s.removal_seen;
            if (!detect_on || removal_pulse || state_r == ppc_pkg::ST_SLEEP) begin
                attached_r <= 1'b0;
            end
            if (detect_on && attach_pulse && state_r == ppc_pkg::ST_DETECT) begin
                attached_r <= 1'b1;
            end
        end
    end

    // Power state the pins ask for when no error is pending.
    always_comb begin
        want = ppc_pkg::ST_SLEEP;
        if (!core_ok || !cap_done_r) begin
            want = ppc_pkg::ST_SLEEP;
        end else if (det_en && !(en_on && modes_zero)) begin
            if (en_on && src_ok && !modes_zero && attached_r) begin
                want = ppc_pkg::ST_ACTIVE;
            end else begin
                want = ppc_pkg::ST_DETECT;
            end
        end else if (!det_en && en_on && src_ok && !modes_zero) begin
            want = ppc_pkg::ST_ACTIVE;
        end
    end

    // ----------------------------------------------------------------
    // Fault qualification over the mask time
    // ----------------------------------------------------------------
    logic [ppc_pkg::NFQ-1:0] fq_cond;
    logic [ppc_pkg::NFQ-1:0] fq_hit;
    logic [ppc_pkg::NFQ-1:0][ppc_pkg::MASK_W-1:0] fq_cnt_r;
    localparam logic [ppc_pkg::MASK_W-1:0] MASK_TOP = ppc_pkg::MASK_W'(MASK_CYC + 1);

    // A back-voltage keeps counting once started, though its switch is now open.
    assign fq_cond[ppc_pkg::FI_BVS] = s_s.bv_source &&
        (sw.main_on || fq_cnt_r[ppc_pkg::FI_BVS] != '0);
    assign fq_cond[ppc_pkg::FI_BVC] = s_s.bv_core &&
        (sw.bypass_on || fq_cnt_r[ppc_pkg::FI_BVC] != '0);
    assign fq_cond[ppc_pkg::FI_OV] = s_s.source_ov;
    assign fq_cond[ppc_pkg::FI_EXT] = s_s.other_fault && state_r == ppc_pkg::ST_ACTIVE;

    genvar gi;
    generate
        for (gi = 0; gi < ppc_pkg::NFQ; gi++) begin : g_fq
            assign fq_hit[gi] = fq_cnt_r[gi] == MASK_TOP;
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    fq_cnt_r[gi] <= '0;
                end else if (!fq_cond[gi]) begin
                    fq_cnt_r[gi] <= '0;
                end else if (!fq_hit[gi]) begin
                    fq_cnt_r[gi] <= fq_cnt_r[gi] + 1'b1;
                end
            end
        end
    endgenerate

    wire bv_hit = fq_hit[ppc_pkg::FI_BVS] || fq_hit[ppc_pkg::FI_BVC];
    // Thermal shutdown bypasses the mask qualification.
    wire err_trig = state_r != ppc_pkg::ST_ERROR &&
        (|fq_hit || (s_s.thermal_shutdown && state_r != ppc_pkg::ST_SLEEP));
    wire all_clear = !(s_s.bv_source || s_s.bv_core || s_s.source_ov ||
        s_s.other_fault || s_s.thermal_shutdown);

    // ----------------------------------------------------------------
    // Error recovery
    // ----------------------------------------------------------------
    logic [ppc_pkg::CNT_W-1:0] cyc_cnt_r;
    logic pe_low_seen_r;
    wire in_err = state_r == ppc_pkg::ST_ERROR;
    wire cyc_done = cyc_cnt_r >= ppc_pkg::CNT_W'(CYCLE_CYC);
    wire recheck = in_err && (removal_pulse ||
        (c_s.latch_select ? (pe_low_seen_r && en_on) : cyc_done));

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cyc_cnt_r <= '0;
            pe_low_seen_r <= 1'b0;
        end else begin
            if (!in_err || recheck) begin
                cyc_cnt_r <= '0;
            end else if (!cyc_done) begin
                cyc_cnt_r <= cyc_cnt_r + 1'b1;
            end
            if (!in_err || recheck) begin
                pe_low_seen_r <= 1'b0;
            end else if (!en_on) begin
                pe_low_seen_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Power state machine
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ppc_pkg::ST_SLEEP, ppc_pkg::ST_DETECT, ppc_pkg::ST_ACTIVE: begin
                if (err_trig) begin
                    state_nxt = ppc_pkg::ST_ERROR;
                end else begin
                    state_nxt = want;
                end
            end
            ppc_pkg::ST_ERROR: begin
                if (recheck && all_clear) begin
                    state_nxt = want;
                end
            end
            default: state_nxt = ppc_pkg::ST_SLEEP;
        endcase
    end

    // ----------------------------------------------------------------
    // Switch drives
    // ----------------------------------------------------------------
    wire go_active = state_r == ppc_pkg::ST_ACTIVE && state_nxt == ppc_pkg::ST_ACTIVE;
    // The main switch reopens at once on source back-voltage and recloses after.
    assign sw_nxt.main_on = go_active && en_on && src_ok &&
        !s_s.bv_source && !s_s.source_ov;
    assign sw_nxt.bypass_on = state_r == ppc_pkg::ST_DETECT &&
        state_nxt == ppc_pkg::ST_DETECT && !s_s.bv_core;
    assign sw_nxt.data_on = go_active && core_ok &&
        !s_s.emulating_non_cdp && !s_s.dedicated_charger;

    logic bv_flag_r;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ppc_pkg::ST_SLEEP;
            sw <= '0;
            bv_flag_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            sw <= sw_nxt;
            if (bv_hit && !in_err) begin
                bv_flag_r <= 1'b1;
            end else if (in_err && state_nxt != ppc_pkg::ST_ERROR) begin
                bv_flag_r <= 1'b0;
            end
        end
    end

    assign power_state = state_r;
    assign back_voltage_flag = bv_flag_r;
    assign limit_step = limit_step_r;

    // ----------------------------------------------------------------
    // Indicators
    // ----------------------------------------------------------------
    // The overload toggle runs at clock rate; the pin only needs to keep cycling.
    wire overload_cycle = det_en && en_on && !src_ok && s_s.bypass_overload;
    logic attach_oe_nxt;

    always_comb begin
        attach_oe_nxt = 1'b0;
        if (!CHARGE_VARIANT && blank_done_r) begin
            if (state_r == ppc_pkg::ST_ACTIVE && !det_en) begin
                attach_oe_nxt = 1'b1;
            end else if (overload_cycle) begin
                attach_oe_nxt = !attach_indicator_n_oe;
            end else begin
                attach_oe_nxt = attached_r;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            alert_n_oe <= 1'b0;
            charging_active_n_oe <= 1'b0;
            attach_indicator_n_oe <= 1'b0;
            alert_n_o <= 1'b0;
            charging_active_n_o <= 1'b0;
            attach_indicator_n_o <= 1'b0;
        end else begin
            alert_n_oe <= blank_done_r && in_err;
            charging_active_n_oe <= CHARGE_VARIANT && blank_done_r && s_s.charging_now;
            attach_indicator_n_oe <= attach_oe_nxt;
            alert_n_o <= 1'b0;
            charging_active_n_o <= 1'b0;
            attach_indicator_n_o <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_err_entry;
        state_r != ppc_pkg::ST_ERROR ##1 state_r == ppc_pkg::ST_ERROR;
    endsequence

    sequence s_pe_toggle;
        !en_on ##1 en_on;
    endsequence

    a_main_needs_enable: assert property (sw.main_on |-> $past(en_on))
        else $error("main switch closed without power enable");
    a_main_needs_source: assert property (sw.main_on |-> $past(src_ok))
        else $error("main switch closed below source lockout");
    a_bv_opens_main: assert property (s_s.bv_source && sw.main_on |=> !sw.main_on)
        else $error("main switch stayed closed on back-voltage");
    a_bv_opens_bypass: assert property (s_s.bv_core && sw.bypass_on |=> !sw.bypass_on)
        else $error("bypass switch stayed closed on back-voltage");
    a_error_all_off: assert property (s_err_entry |=> sw == '0 [*3])
        else $error("switch on while in error");
    a_ov_to_error: assert property
        (fq_hit[ppc_pkg::FI_OV] && state_r != ppc_pkg::ST_ERROR |=> in_err)
        else $error("over-voltage past mask did not enter error");
    a_pol_held: assert property (cap_done_r |=> $stable(pol_r))
        else $error("enable polarity changed after capture");
    a_blank_quiet: assert property (!blank_done_r |=>
        !alert_n_oe && !charging_active_n_oe && !attach_indicator_n_oe)
        else $error("indicator asserted during blanking");
    a_data_core_low: assert property (!core_ok |=> !sw.data_on)
        else $error("data switch closed with core supply low");
    a_alert_follows_err: assert property (blank_done_r && in_err |=> alert_n_oe)
        else $error("alert not asserted in error");
    a_latch_recheck: assert property (in_err && c_s.latch_select && all_clear &&
        !removal_pulse ##0 s_pe_toggle |-> ##[0:1] !in_err || !all_clear)
        else $error("latched recovery ignored enable toggle");

endmodule // ppc_ctrl

// [src/ppc_pkg.sv]
// Shared constants and types for the port power control logic.
package ppc_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned T_MASK_NS = 5000;
    localparam int unsigned T_BLANK_NS = 1000000;
    localparam int unsigned T_CYCLE_NS = 25000000;
    // Mask is a least time (round up); blanking and cycle are longest times.
    localparam int unsigned MASK_CYC = (T_MASK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BLANK_CYC = T_BLANK_NS / CLK_PERIOD_NS;
    localparam int unsigned CYCLE_CYC = T_CYCLE_NS / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 24;
    localparam int unsigned MASK_W = 16;
    localparam logic [CNT_W-1:0] CAPTURE_AT = 24'h000003;

    // ----------------------------------------------------------------
    // Fault qualifier slots and reset values
    // ----------------------------------------------------------------
    localparam int unsigned FI_BVS = 0;
    localparam int unsigned FI_BVC = 1;
    localparam int unsigned FI_OV = 2;
    localparam int unsigned FI_EXT = 3;
    localparam int unsigned NFQ = 4;
    localparam logic [2:0] LIMIT_STEP_RST = 3'h0;
    localparam logic POL_RST = 1'b1;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_SLEEP, ST_DETECT, ST_ACTIVE, ST_ERROR} ppc_state_t;

    typedef struct packed {
        logic power_enable;
        logic polarity_select;
        logic detect_enable;
        logic mode_select_a;
        logic mode_select_b;
        logic emulation_enable;
        logic latch_select;
        logic [2:0] current_limit_strap;
    } ppc_ctl_t;

    typedef struct packed {
        logic bv_source;
        logic bv_core;
        logic source_ov;
        logic source_above_uvlo;
        logic core_supply_ok;
        logic thermal_shutdown;
        logic other_fault;
        logic attach_seen;
        logic removal_seen;
        logic charging_now;
        logic bypass_overload;
        logic emulating_non_cdp;
        logic dedicated_charger;
    } ppc_sense_t;

    typedef struct packed {
        logic main_on;
        logic bypass_on;
        logic data_on;
    } ppc_sw_t;

endpackage

// [src/ppc_sync.sv]
// Two-flop synchroniser for a bundle of asynchronous levels.
module ppc_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule // ppc_sync

// [verification/ppc_ctrl_tb.sv]
// Self-checking testbench of the port power controller.
module ppc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned MC = 8;
    localparam int unsigned BC = 16;
    localparam int unsigned CC = 32;
    localparam int O_ST = 0;
    localparam int O_DATA = 2;
    localparam int O_BYP = 3;
    localparam int O_MAIN = 4;
    localparam int O_BV = 5;
    localparam int O_ALERT = 6;
    localparam int O_ATT = 7;
    localparam int O_LIM = 8;
    localparam int O_CHG = 11;

    typedef struct {
        string name;
        int lo;
        logic [2:0] exp;
    } ppc_note_t;

    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    ppc_pkg::ppc_ctl_t ctl;
    ppc_pkg::ppc_sense_t sense;
    ppc_pkg::ppc_sw_t sw;
    ppc_pkg::ppc_state_t power_state;
    logic bv_flag;
    logic [2:0] limit_step;
    logic alert_oe;
    logic chg_oe;
    logic att_oe;
    logic alert_pin_n;
    logic att_pin_n;
    logic chg_pin_n;
    wire logic [11:0] obs_w;
    logic [2:0] tog = 3'h0;
    logic [31:0] lfsr = 32'h405B;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    ppc_note_t notes[$];
    event got_ev;

    assign obs_w = {chg_pin_n, limit_step, att_pin_n, alert_pin_n, bv_flag, sw, power_state};

    always #10 mclk = ~mclk;

    ppc_ctrl #(.MASK_CYC(MC), .BLANK_CYC(BC), .CYCLE_CYC(CC), .CHARGE_VARIANT(1'b0)) i_ppc_ctrl (
        .mclk(mclk), .reset_n(reset_n), .ctl(ctl), .sense(sense), .sw(sw),
        .power_state(power_state), .back_voltage_flag(bv_flag), .limit_step(limit_step),
        .alert_n_o(), .alert_n_oe(alert_oe), .charging_active_n_o(),
        .charging_active_n_oe(chg_oe), .attach_indicator_n_o(),
        .attach_indicator_n_oe(att_oe));

    ppc_host i_ppc_host (
        .mclk(mclk), .ctl(ctl), .alert_oe(alert_oe), .attach_oe(att_oe),
        .charge_oe(chg_oe), .alert_pin_n(alert_pin_n), .attach_pin_n(att_pin_n),
        .charge_pin_n(chg_pin_n));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [2:0] field(input int lo);
        if (lo < 0) begin
            return tog;
        end
        return 3'(obs_w >> lo) & ((lo == 0) ? 3'h3 : (lo == 8) ? 3'h7 : 3'h1);
    endfunction

    task automatic check(input string name, input logic [2:0] seen_v, input logic [2:0] exp);
        n_tests++;
        if (seen_v !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen_v);
        end
    endtask

    // Notes the expectation, then waits a bounded time for the result to show.
    task automatic expect_v(input string name, input int lo, input logic [2:0] e, input int lim);
        int k;
        notes.push_back('{name, lo, e});
        for (k = 0; k < lim && field(lo) !== e; k++) @(negedge mclk);
        -> got_ev;
        @(negedge mclk);
    endtask

    task automatic sb(input int b, input logic v);
        @(posedge mclk);
        #2;
        sense[b] = v;
    endtask

    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(got_ev) begin
        ppc_note_t n;
        n = notes.pop_front();
        check(n.name, field(n.lo), n.exp);
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int k;
        logic [2:0] lim;
        logic mb;
        sense = '0;
        sense.source_above_uvlo = 1'b1;
        sense.core_supply_ok = 1'b1;
        lfsr = lfsr_next(lfsr);
        lim = lfsr[2:0];
        mb = lfsr[8];
        i_ppc_host.strap(1'b1, lim);
        i_ppc_host.pins(1'b0, 1'b1, mb, 1'b0);
        @(posedge mclk);
        #2;
        reset_n = 1'b1;
        expect_v("state", O_ST, ppc_pkg::ST_ACTIVE, 20);
        repeat (6) expect_v("attach", O_ATT, 3'h1, 0);
        expect_v("limit step", O_LIM, lim, 0);
        i_ppc_host.strap(1'b0, ~lim);
        repeat (6) expect_v("limit step", O_LIM, lim, 0);
        expect_v("state", O_ST, ppc_pkg::ST_ACTIVE, 0);
        expect_v("main", O_MAIN, 3'h1, 0);
        expect_v("data", O_DATA, 3'h1, 0);
        expect_v("attach", O_ATT, 3'h0, BC + 4);
        sb(3, 1'b1);
        repeat (4) expect_v("charge", O_CHG, 3'h1, 0);
        sb(3, 1'b0);
        done("capture and forced attach");
        for (k = 0; k < 2; k++) begin
            sb(k, 1'b1);
            expect_v("data", O_DATA, 3'h0, 6);
            sb(k, 1'b0);
            expect_v("data", O_DATA, 3'h1, 6);
        end
        sb(8, 1'b0);
        expect_v("data", O_DATA, 3'h0, 6);
        sb(8, 1'b1);
        expect_v("data", O_DATA, 3'h1, 12);
        i_ppc_host.power(1'b0);
        expect_v("main", O_MAIN, 3'h0, 6);
        repeat (3) expect_v("main", O_MAIN, 3'h0, 0);
        i_ppc_host.power(1'b1);
        expect_v("main", O_MAIN, 3'h1, 10);
        done("data switch and enable");
        sb(12, 1'b1);
        expect_v("main", O_MAIN, 3'h0, 5);
        sb(12, 1'b0);
        expect_v("main", O_MAIN, 3'h1, 5);
        expect_v("state", O_ST, ppc_pkg::ST_ACTIVE, 0);
        sb(12, 1'b1);
        repeat (MC) expect_v("alert", O_ALERT, 3'h1, 0);
        expect_v("state", O_ST, ppc_pkg::ST_ERROR, 8);
        expect_v("bv flag", O_BV, 3'h1, 0);
        expect_v("data", O_DATA, 3'h0, 0);
        expect_v("main", O_MAIN, 3'h0, 0);
        expect_v("bypass", O_BYP, 3'h0, 0);
        expect_v("alert", O_ALERT, 3'h0, 3);
        sb(12, 1'b0);
        repeat (CC / 2) expect_v("state", O_ST, ppc_pkg::ST_ERROR, 0);
        expect_v("state", O_ST, ppc_pkg::ST_ACTIVE, CC + 20);
        expect_v("alert", O_ALERT, 3'h1, 3);
        expect_v("bv flag", O_BV, 3'h0, 0);
        done("back-voltage auto recovery");
        i_ppc_host.pins(1'b0, 1'b1, mb, 1'b1);
        sb(10, 1'b1);
        expect_v("state", O_ST, ppc_pkg::ST_ERROR, MC + 8);
        expect_v("main", O_MAIN, 3'h0, 2);
        sb(10, 1'b0);
        repeat (CC + 8) expect_v("state", O_ST, ppc_pkg::ST_ERROR, 0);
        i_ppc_host.power(1'b0);
        repeat (3) @(posedge mclk);
        i_ppc_host.power(1'b1);
        expect_v("state", O_ST, ppc_pkg::ST_ACTIVE, 10);
        sb(7, 1'b1);
        expect_v("state", O_ST, ppc_pkg::ST_ERROR, 4);
        expect_v("alert", O_ALERT, 3'h0, 2);
        sb(7, 1'b0);
        i_ppc_host.pins(1'b0, 1'b1, mb, 1'b0);
        expect_v("state", O_ST, ppc_pkg::ST_ACTIVE, CC + 20);
        done("latched and thermal faults");
        sb(9, 1'b0);
        expect_v("main", O_MAIN, 3'h0, 6);
        repeat (3) expect_v("main", O_MAIN, 3'h0, 0);
        sb(9, 1'b1);
        expect_v("main", O_MAIN, 3'h1, 10);
        i_ppc_host.pins(1'b1, 1'b1, mb, 1'b0);
        expect_v("state", O_ST, ppc_pkg::ST_DETECT, 8);
        expect_v("bypass", O_BYP, 3'h1, 0);
        repeat (4) expect_v("main", O_MAIN, 3'h0, 0);
        sb(5, 1'b1);
        expect_v("state", O_ST, ppc_pkg::ST_ACTIVE, 6);
        expect_v("attach", O_ATT, 3'h0, 3);
        sb(5, 1'b0);
        sb(4, 1'b1);
        expect_v("attach", O_ATT, 3'h1, 6);
        sb(4, 1'b0);
        sb(9, 1'b0);
        sb(2, 1'b1);
        repeat (6) @(negedge mclk);
        repeat (4) begin
            @(negedge mclk);
            tog = tog + {2'h0, att_pin_n};
        end
        expect_v("toggle count", -1, 3'h2, 0);
        sb(2, 1'b0);
        sb(9, 1'b1);
        done("attach detection");
        i_ppc_host.pins(1'b1, 1'b0, 1'b0, 1'b0);
        expect_v("state", O_ST, ppc_pkg::ST_SLEEP, 8);
        sb(5, 1'b1);
        repeat (4) expect_v("main", O_MAIN, 3'h0, 0);
        sb(5, 1'b0);
        i_ppc_host.pins(1'b0, 1'b1, mb, 1'b0);
        expect_v("attach", O_ATT, 3'h0, 10);
        sb(4, 1'b1);
        repeat (4) expect_v("attach", O_ATT, 3'h0, 0);
        sb(4, 1'b0);
        done("detection disabled");
        report_and_stop();
    end
endmodule // ppc_ctrl_tb

// [verification/ppc_host.sv]
// Host model: drives the control pins and resolves the open-drain indicator pins.
module ppc_host #(
    parameter bit BOOT_POL = 1'b1
) (
    // Clock
    input wire logic mclk,
    // Control pins towards the controller
    output ppc_pkg::ppc_ctl_t ctl,
    // Indicator enables and the resolved pin levels
    input wire logic alert_oe,
    input wire logic attach_oe,
    input wire logic charge_oe,
    output logic alert_pin_n,
    output logic attach_pin_n,
    output logic charge_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Board pull-ups hold every released indicator high.
    assign alert_pin_n = alert_oe ? 1'b0 : 1'b1;
    assign attach_pin_n = attach_oe ? 1'b0 : 1'b1;
    assign charge_pin_n = charge_oe ? 1'b0 : 1'b1;

    initial begin
        ctl = '0;
        ctl.polarity_select = BOOT_POL;
        ctl.power_enable = BOOT_POL;
        ctl.mode_select_a = 1'b1;
    end

    // The host keeps the polarity it strapped at power-up, whatever the pin shows later.
    task automatic power(input logic on);
        @(posedge mclk);
        #2;
        ctl.power_enable = on ~^ BOOT_POL;
    endtask

    task automatic pins(input logic det, input logic ma, input logic mb, input logic lat);
        @(posedge mclk);
        #2;
        ctl.detect_enable = det;
        ctl.mode_select_a = ma;
        ctl.mode_select_b = mb;
        ctl.latch_select = lat;
    endtask

    task automatic strap(input logic pol, input logic [2:0] lim);
        @(posedge mclk);
        #2;
        ctl.polarity_select = pol;
        ctl.current_limit_strap = lim;
    endtask
endmodule // ppc_host
